// >>> inc/adsq_cfg.svh
// Purpose: offsets, field positions, reset values of the sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: ranges are written as msb:lsb for use inside brackets
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH
`define ADSQ_OFS_MODE 8'h00
`define ADSQ_OFS_PRIO 8'h04
`define ADSQ_OFS_MON 8'h08
`define ADSQ_OFS_TRIG 8'h0c
`define ADSQ_OFS_PRES 8'h10
`define ADSQ_RES_BASE 3'h1
`define ADSQ_MODE_START 0
`define ADSQ_MODE_SCAN 1
`define ADSQ_MODE_RPT 2
`define ADSQ_MODE_ITM 4:3
`define ADSQ_MODE_DONE 6
`define ADSQ_MODE_BUSY 7
`define ADSQ_MODE_CH 11:8
`define ADSQ_PRIO_CH 3:0
`define ADSQ_PRIO_START 4
`define ADSQ_PRIO_DONE 5
`define ADSQ_PRIO_BUSY 6
`define ADSQ_MON_EN 0
`define ADSQ_MON_DIR 1
`define ADSQ_MON_SEL 7:4
`define ADSQ_MON_THR 25:16
`define ADSQ_TRIG_HPSEL 7:6
`define ADSQ_RES_DATA 9:0
`define ADSQ_RES_OVR 14
`define ADSQ_RES_STORED 15
`define ADSQ_HPSRC_PIN 2'h1
`define ADSQ_HPSRC_TMR 2'h2
`define ADSQ_ITM_1 2'h0
`define ADSQ_ITM_4 2'h1
`define ADSQ_LIM_1 3'h0
`define ADSQ_LIM_4 3'h3
`define ADSQ_LIM_8 3'h7
`define ADSQ_RST_CH 4'h0
`define ADSQ_RST_THR 10'h000
`define ADSQ_RST_SEL 2'h0
`endif

// >>> inc/adsq_pkg.sv
// Purpose: types shared by the sequencer
// Assumes: nothing
// Notes: state codes are one-hot
`default_nettype none
package adsq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_NORM = 3'b010,
    ST_PRIO = 3'b100
  } adsq_state_t;
  typedef struct packed {
    logic stored;
    logic ovr;
    logic [9:0] data;
  } adsq_res_t;
  typedef struct packed {
    logic start;
    logic abort;
    logic [3:0] chan;
  } adsq_conv_t;
  typedef struct packed {
    logic scan;
    logic rpt;
    logic [1:0] itm;
    logic [3:0] ch;
  } adsq_mode_t;
endpackage
`default_nettype wire

// >>> verilog/adsq_seq.sv
// Purpose: converter sequencer with preemptive priority and monitor
// Assumes: core pulses convDone with convData on mclk, same domain
// Notes: APB slave answers one cycle into the access phase
// Overview of operation
// - mode 11 converts scan group 0..ch over and over
// - each scan pass sets done flag and irq, busy stays 1
// - reading done flags clears them
// - clearing repeat bit ends run after current conversion, busy 0
// - priority conversion is always fixed channel single
// - priority converts its channel once, then irq, done, busy 0
// - priority starts by start bit or selected hardware trigger
// - priority suspends normal, stores own result, normal resumes
// - normal resumes at the suspended channel
// - priority trigger during priority conversion is ignored
// - monitor compares selected result with threshold, direction bit
// - comparison on each store, irq each time condition holds
// - monitored register flags end up set, not to be relied on
// - eight result registers, channel n and n+8 share n mod 8
// - fixed repeat interval 1 uses first, 4 fills first four
// - codes 00 fixed single, 01 scan single, 10 fixed repeat
// - interval field 00/01/10 signals every 1/4/8 conversions
// - start bit write in ST_IDLE, no priority pending, starts normal run and sets busy
//
// Added by the designer: register access over APB and the register addresses.
`include "adsq_cfg.svh"
`default_nettype none
module adsq_seq (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convDone,
  input wire logic [9:0] convData,
  input wire logic trigPin_n,
  input wire logic trigTimer,
  output var adsq_pkg::adsq_conv_t convReq,
  output logic normalDoneIrq,
  output logic priorityDoneIrq,
  output logic monitorIrq
);
  logic [1:0] rstSync;
  logic rst_n;
  logic setupAcc, acc, wr, rd, resHit, mapped;
  logic [2:0] resIdx;
  adsq_pkg::adsq_mode_t mode_r, run_r;
  adsq_pkg::adsq_state_t state_r;
  adsq_pkg::adsq_conv_t convReq_r;
  adsq_pkg::adsq_res_t res_r [8];
  logic [3:0] priorityChannel_r, monSel_r, curCh_r, nextCh;
  logic [9:0] monThr_r, prioRes_r;
  logic [1:0] hpSel_r;
  logic monitorEnable_r, monitorDirection_r;
  logic normalDoneFlag_r, normalBusyFlag_r;
  logic priorityDoneFlag_r, priorityBusyFlag_r, prioPend_r;
  logic [2:0] fill_r, nextFill, lim, resWIdx;
  logic [2:0] pinSync, tmrSync;
  logic normStartWr, prioTrig, enterPrio, prioDoneEv;
  logic normEv, stopNorm, resWe, fixedRpt, monHit;
  logic [31:0] rdMux;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, nIrq_r, pIrq_r, mIrq_r;

  // reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rstSync <= 2'h0;
    else rstSync <= {rstSync[0], 1'b1};
  end
  assign rst_n = rstSync[1];

  // apb phase decode
  assign setupAcc = psel & penable & ~pready_r;
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign resHit = (paddr[7:5] == `ADSQ_RES_BASE) & (paddr[1:0] == 2'h0);
  assign resIdx = paddr[4:2];
  assign mapped = resHit | (paddr == `ADSQ_OFS_MODE) |
    (paddr == `ADSQ_OFS_PRIO) | (paddr == `ADSQ_OFS_MON) |
    (paddr == `ADSQ_OFS_TRIG) | (paddr == `ADSQ_OFS_PRES);

  // control registers written by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= '0;
      priorityChannel_r <= `ADSQ_RST_CH;
      monitorEnable_r <= 1'b0;
      monitorDirection_r <= 1'b0;
      monSel_r <= `ADSQ_RST_CH;
      monThr_r <= `ADSQ_RST_THR;
      hpSel_r <= `ADSQ_RST_SEL;
    end else if (wr) begin
      case (paddr)
        `ADSQ_OFS_MODE: begin
          mode_r.scan <= pwdata[`ADSQ_MODE_SCAN];
          mode_r.rpt <= pwdata[`ADSQ_MODE_RPT];
          mode_r.itm <= pwdata[`ADSQ_MODE_ITM];
          mode_r.ch <= pwdata[`ADSQ_MODE_CH];
        end
        `ADSQ_OFS_PRIO: priorityChannel_r <= pwdata[`ADSQ_PRIO_CH];
        `ADSQ_OFS_MON: begin
          monitorEnable_r <= pwdata[`ADSQ_MON_EN];
          monitorDirection_r <= pwdata[`ADSQ_MON_DIR];
          monSel_r <= pwdata[`ADSQ_MON_SEL];
          monThr_r <= pwdata[`ADSQ_MON_THR];
        end
        `ADSQ_OFS_TRIG: hpSel_r <= pwdata[`ADSQ_TRIG_HPSEL];
        default: ;
      endcase
    end
  end

  // trigger pins: sync, then edge on the settled copies
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync <= 3'h7;
      tmrSync <= 3'h0;
    end else begin
      pinSync <= {pinSync[1:0], trigPin_n};
      tmrSync <= {tmrSync[1:0], trigTimer};
    end
  end

  assign normStartWr = wr & (paddr == `ADSQ_OFS_MODE) &
    pwdata[`ADSQ_MODE_START];
  assign prioTrig = (wr & (paddr == `ADSQ_OFS_PRIO) &
    pwdata[`ADSQ_PRIO_START]) |
    ((hpSel_r == `ADSQ_HPSRC_PIN) & pinSync[2] & ~pinSync[1]) |
    ((hpSel_r == `ADSQ_HPSRC_TMR) & ~tmrSync[2] & tmrSync[1]);
  assign enterPrio = prioPend_r & (state_r != adsq_pkg::ST_PRIO);
  assign prioDoneEv = (state_r == adsq_pkg::ST_PRIO) & convDone;

  // accept only while no priority conversion is busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prioPend_r <= 1'b0;
      priorityBusyFlag_r <= 1'b0;
    end else begin
      if (prioTrig & ~priorityBusyFlag_r) prioPend_r <= 1'b1;
      else if (enterPrio) prioPend_r <= 1'b0;
      if (prioTrig & ~priorityBusyFlag_r) priorityBusyFlag_r <= 1'b1;
      else if (prioDoneEv) priorityBusyFlag_r <= 1'b0;
    end
  end

  // completion decode for a normal conversion
  assign fixedRpt = run_r.rpt & ~run_r.scan;
  always_comb begin
    normEv = 1'b0;
    stopNorm = 1'b0;
    resWe = 1'b0;
    nextCh = curCh_r;
    nextFill = fill_r;
    resWIdx = curCh_r[2:0];
    case (run_r.itm)
      `ADSQ_ITM_1: lim = `ADSQ_LIM_1;
      `ADSQ_ITM_4: lim = `ADSQ_LIM_4;
      default: lim = `ADSQ_LIM_8;
    endcase
    if ((state_r == adsq_pkg::ST_NORM) & convDone) begin
      resWe = 1'b1;
      if (run_r.scan) begin
        // wrap to the group start after the last channel
        if (curCh_r == run_r.ch) begin
          normEv = 1'b1;
          nextCh = 4'h0;
          stopNorm = ~run_r.rpt;
        end else begin
          nextCh = curCh_r + 4'h1;
        end
      end else if (fixedRpt) begin
        // fill first 1/4/8 result registers in order
        resWIdx = fill_r;
        if (fill_r == lim) begin
          normEv = 1'b1;
          nextFill = 3'h0;
        end else begin
          nextFill = fill_r + 3'h1;
        end
      end else begin
        normEv = 1'b1;
        stopNorm = 1'b1;
      end
      // repeat cleared: end after this conversion
      if (run_r.rpt & ~mode_r.rpt) begin
        stopNorm = 1'b1;
        normEv = 1'b1;
      end
    end
  end

  // sequencer state, channel walk and core requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adsq_pkg::ST_IDLE;
      run_r <= '0;
      curCh_r <= 4'h0;
      fill_r <= 3'h0;
      normalBusyFlag_r <= 1'b0;
      convReq_r <= '0;
    end else begin
      convReq_r.start <= 1'b0;
      convReq_r.abort <= 1'b0;
      case (state_r)
        adsq_pkg::ST_IDLE: begin
          if (enterPrio) begin
            state_r <= adsq_pkg::ST_PRIO;
            convReq_r.start <= 1'b1;
            convReq_r.chan <= priorityChannel_r;
          end else if (normStartWr) begin
            state_r <= adsq_pkg::ST_NORM;
            run_r <= mode_r;
            run_r.scan <= pwdata[`ADSQ_MODE_SCAN];
            run_r.rpt <= pwdata[`ADSQ_MODE_RPT];
            run_r.itm <= pwdata[`ADSQ_MODE_ITM];
            run_r.ch <= pwdata[`ADSQ_MODE_CH];
            curCh_r <= pwdata[`ADSQ_MODE_SCAN] ? 4'h0 :
              pwdata[`ADSQ_MODE_CH];
            fill_r <= 3'h0;
            normalBusyFlag_r <= 1'b1;
            convReq_r.start <= 1'b1;
            convReq_r.chan <= pwdata[`ADSQ_MODE_SCAN] ? 4'h0 :
              pwdata[`ADSQ_MODE_CH];
          end
        end
        adsq_pkg::ST_NORM: begin
          if (convDone) begin
            curCh_r <= nextCh;
            fill_r <= nextFill;
            if (stopNorm) normalBusyFlag_r <= 1'b0;
            if (enterPrio) begin
              state_r <= adsq_pkg::ST_PRIO;
              convReq_r.start <= 1'b1;
              convReq_r.chan <= priorityChannel_r;
            end else if (stopNorm) begin
              state_r <= adsq_pkg::ST_IDLE;
            end else begin
              convReq_r.start <= 1'b1;
              convReq_r.chan <= run_r.scan ? nextCh : run_r.ch;
            end
          end else if (enterPrio) begin
            // suspend the normal conversion, keep its state
            state_r <= adsq_pkg::ST_PRIO;
            convReq_r.abort <= 1'b1;
            convReq_r.start <= 1'b1;
            convReq_r.chan <= priorityChannel_r;
          end
        end
        adsq_pkg::ST_PRIO: begin
          if (convDone) begin
            if (normalBusyFlag_r) begin
              state_r <= adsq_pkg::ST_NORM;
              convReq_r.start <= 1'b1;
              convReq_r.chan <= curCh_r;
            end else begin
              state_r <= adsq_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= adsq_pkg::ST_IDLE;
      endcase
    end
  end

  // done flags, set wins over read clear
  // a read clears only a flag that its data showed, so no event is lost
  // pass end sets done while busy holds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      normalDoneFlag_r <= 1'b0;
      priorityDoneFlag_r <= 1'b0;
      prioRes_r <= 10'h000;
    end else begin
      normalDoneFlag_r <= normEv |
        (normalDoneFlag_r & ~(rd & (paddr == `ADSQ_OFS_MODE) &
        prdata_r[`ADSQ_MODE_DONE]));
      priorityDoneFlag_r <= prioDoneEv |
        (priorityDoneFlag_r & ~(rd & (paddr == `ADSQ_OFS_PRIO) &
        prdata_r[`ADSQ_PRIO_DONE]));
      if (prioDoneEv) prioRes_r <= convData;
    end
  end

  // eight result entries, read clears stored and overrun
  // unread monitored entries keep stored and overrun set
  for (genvar i = 0; i < 8; i++) begin : g_res
    logic wrThis, rdThis;
    assign wrThis = resWe & (resWIdx == 3'(i));
    assign rdThis = rd & resHit & (resIdx == 3'(i));
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        res_r[i] <= '0;
      end else begin
        if (wrThis) res_r[i].data <= convData;
        // clear only what the returned word showed
        res_r[i].stored <= wrThis | (res_r[i].stored &
          ~(rdThis & prdata_r[`ADSQ_RES_STORED]));
        res_r[i].ovr <= (wrThis & res_r[i].stored) |
          (res_r[i].ovr & ~(rdThis & prdata_r[`ADSQ_RES_OVR]));
      end
    end
  end

  // evaluated on every store into the watched entry
  assign monHit = resWe & monitorEnable_r & ~monSel_r[3] &
    (resWIdx == monSel_r[2:0]) &
    (monitorDirection_r ? (convData > monThr_r) : (convData < monThr_r));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nIrq_r <= 1'b0;
      pIrq_r <= 1'b0;
      mIrq_r <= 1'b0;
    end else begin
      nIrq_r <= normEv;
      pIrq_r <= prioDoneEv;
      mIrq_r <= monHit;
    end
  end

  // read data selection
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      `ADSQ_OFS_MODE: begin
        rdMux[`ADSQ_MODE_SCAN] = mode_r.scan;
        rdMux[`ADSQ_MODE_RPT] = mode_r.rpt;
        rdMux[`ADSQ_MODE_ITM] = mode_r.itm;
        rdMux[`ADSQ_MODE_DONE] = normalDoneFlag_r;
        rdMux[`ADSQ_MODE_BUSY] = normalBusyFlag_r;
        rdMux[`ADSQ_MODE_CH] = mode_r.ch;
      end
      `ADSQ_OFS_PRIO: begin
        rdMux[`ADSQ_PRIO_CH] = priorityChannel_r;
        rdMux[`ADSQ_PRIO_DONE] = priorityDoneFlag_r;
        rdMux[`ADSQ_PRIO_BUSY] = priorityBusyFlag_r;
      end
      `ADSQ_OFS_MON: begin
        rdMux[`ADSQ_MON_EN] = monitorEnable_r;
        rdMux[`ADSQ_MON_DIR] = monitorDirection_r;
        rdMux[`ADSQ_MON_SEL] = monSel_r;
        rdMux[`ADSQ_MON_THR] = monThr_r;
      end
      `ADSQ_OFS_TRIG: rdMux[`ADSQ_TRIG_HPSEL] = hpSel_r;
      `ADSQ_OFS_PRES: rdMux[`ADSQ_RES_DATA] = prioRes_r;
      default: begin
        if (resHit) begin
          rdMux[`ADSQ_RES_DATA] = res_r[resIdx].data;
          rdMux[`ADSQ_RES_OVR] = res_r[resIdx].ovr;
          rdMux[`ADSQ_RES_STORED] = res_r[resIdx].stored;
        end
      end
    endcase
  end

  // apb answer one cycle into access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setupAcc;
      pslverr_r <= setupAcc & ~mapped;
      if (setupAcc) prdata_r <= mapped ? rdMux : 32'h0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign convReq = convReq_r;
  assign normalDoneIrq = nIrq_r;
  assign priorityDoneIrq = pIrq_r;
  assign monitorIrq = mIrq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_oneStart;
    convReq_r.start ##1 !convReq_r.start;
  endsequence

  chk_prio_ignored: assert property (
    priorityBusyFlag_r && prioTrig && state_r == adsq_pkg::ST_PRIO &&
    !convDone |=> state_r == adsq_pkg::ST_PRIO && !convReq_r.start)
    else $error("priority trigger not ignored");
  chk_prio_done: assert property (
    prioDoneEv |=> priorityDoneFlag_r && !priorityBusyFlag_r &&
    priorityDoneIrq)
    else $error("priority completion flags wrong");
  chk_resume_chan: assert property (
    prioDoneEv && normalBusyFlag_r |=> (state_r == adsq_pkg::ST_NORM &&
    convReq_r.chan == curCh_r) and s_oneStart)
    else $error("normal run not resumed on suspended channel");
  chk_preempt_abort: assert property (
    state_r == adsq_pkg::ST_NORM && prioPend_r && !convDone |=>
    convReq_r.abort && convReq_r.chan == $past(priorityChannel_r) &&
    state_r == adsq_pkg::ST_PRIO)
    else $error("preemption did not abort");
  chk_scan_busy: assert property (
    normEv && run_r.scan && run_r.rpt && mode_r.rpt |=>
    normalBusyFlag_r && normalDoneFlag_r && normalDoneIrq)
    else $error("scan pass end flags wrong");
  chk_done_clear: assert property (
    rd && paddr == `ADSQ_OFS_MODE && prdata_r[`ADSQ_MODE_DONE] &&
    !normEv |=> !normalDoneFlag_r)
    else $error("done flag not cleared by read");
  chk_rpt_stop: assert property (
    state_r == adsq_pkg::ST_NORM && convDone && run_r.rpt && !mode_r.rpt
    |=> !normalBusyFlag_r)
    else $error("repeat did not stop");
  chk_start_busy: assert property (
    state_r == adsq_pkg::ST_IDLE && normStartWr && !prioPend_r |=>
    normalBusyFlag_r and s_oneStart)
    else $error("normal start not taken");
  chk_monitor_irq: assert property (
    monHit |=> monitorIrq ##1 (monitorIrq == $past(monHit)))
    else $error("monitor irq missing");
  chk_fixed_first: assert property (
    resWe && fixedRpt && run_r.itm == `ADSQ_ITM_1 |-> resWIdx == 3'h0)
    else $error("interval one not in first register");
  chk_single_prio: assert property (
    prioDoneEv |=> state_r != adsq_pkg::ST_PRIO)
    else $error("priority conversion repeated");
endmodule
`default_nettype wire

// >>> tb/adsq_core_model.sv
// Purpose: behavioural converter core behind the sequencer
// Assumes: start loads a channel, abort drops the running conversion
// Notes: data is {channel, sequence}, inverted every cycle outside done
`default_nettype none
module adsq_core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire adsq_pkg::adsq_conv_t convReq,
  input wire logic [7:0] lat,
  output logic convDone,
  output logic [9:0] convData,
  output logic [5:0] seq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [3:0] ch;
  logic busy;
  // conversion timer; a new start always wins over an abort
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      ch <= 4'h0;
      busy <= 1'b0;
      seq <= 6'h00;
      convDone <= 1'b0;
      convData <= 10'h155;
    end else begin
      convDone <= 1'b0;
      convData <= ~convData;
      if (convReq.start) begin
        busy <= 1'b1;
        cnt <= lat;
        ch <= convReq.chan;
      end else if (convReq.abort) begin
        busy <= 1'b0;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        convDone <= 1'b1;
        convData <= {ch, seq};
        seq <= seq + 6'h01;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_adc_sequencer_priority_monitor.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: core model answers coreLat+1 cycles after a start
// Notes: apb master holds each request until pready is sampled
`include "adsq_cfg.svh"
`default_nettype none
module tb_adc_sequencer_priority_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, convDone, trigPin_n = 1, trigTimer = 0;
  logic nIrq, pIrq, mIrq, err;
  logic [9:0] convData;
  logic [7:0] coreLat = 8'h08;
  logic [5:0] seq;
  adsq_pkg::adsq_conv_t convReq;
  int n_mismatch = 0, n_checks = 0, cN = 0, cP = 0, cM = 0, cD = 0, cA = 0;
  logic [3:0] chLog[$];
  // clock
  always #10ns mclk = ~mclk;
  adsq_seq i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convDone(convDone), .convData(convData), .trigPin_n(trigPin_n),
    .trigTimer(trigTimer), .convReq(convReq), .normalDoneIrq(nIrq),
    .priorityDoneIrq(pIrq), .monitorIrq(mIrq));
  adsq_core_model i_core (.mclk(mclk), .arst_n(arst_n),
    .convReq(convReq), .lat(coreLat), .convDone(convDone),
    .convData(convData), .seq(seq));
  // event counters and log of started channels
  always @(posedge mclk) begin
    if (nIrq === 1'b1) cN++;
    if (pIrq === 1'b1) cP++;
    if (mIrq === 1'b1) cM++;
    if (convDone === 1'b1) cD++;
    if (convReq.abort === 1'b1) cA++;
    if (convReq.start === 1'b1) chLog.push_back(convReq.chan);
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(0, 1, "apb hang");
  endtask
  task automatic wait_for(ref int c, input int tgt, input string what);
    int n;
    n = 0;
    while (c < tgt && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (c < tgt) chk(c, tgt, what);
  endtask
  function automatic logic [31:0] mw(input logic [3:0] ch,
      input logic [1:0] itm, input logic rpt, scan);
    return {20'h0, ch, 3'h0, itm, rpt, scan, 1'b1};
  endfunction
  function automatic logic [7:0] ra(input logic [2:0] n);
    return 8'h20 + {3'h0, n, 2'h0};
  endfunction
  // clear repeat, then poll busy under a bound
  task automatic stop_rpt(input logic [31:0] m);
    int n;
    n = 0;
    apb(1'b1, `ADSQ_OFS_MODE, m & ~32'h5);
    do begin
      apb(1'b0, `ADSQ_OFS_MODE, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 40);
    chk(rd[7], 1'b0, "busy after stop");
  endtask
  task automatic t_single;
    int d0;
    logic [5:0] s0;
    d0 = cN;
    s0 = seq;
    apb(1'b1, `ADSQ_OFS_MODE, mw(4'h9, 2'h0, 1'b0, 1'b0));
    wait_for(cN, d0 + 1, "single irq");
    chk(chLog[$], 4'h9, "single chan");
    apb(1'b0, `ADSQ_OFS_MODE, 0);
    chk(rd[7:6], 2'b01, "done set busy clear");
    apb(1'b0, `ADSQ_OFS_MODE, 0);
    chk(rd[6], 1'b0, "done read clear");
    apb(1'b0, ra(3'h1), 0);
    chk(rd[15:0], {2'b10, 4'h0, 4'h9, s0}, "slot 1");
    apb(1'b0, ra(3'h1), 0);
    chk(rd[15], 1'b0, "stored read clear");
    apb(1'b0, 8'h40, 0);
    chk(err, 1'b1, "unmapped error");
    $display("test single done");
  endtask
  task automatic t_scan;
    int d0, k;
    logic [31:0] m;
    d0 = cN;
    k = chLog.size();
    apb(1'b1, `ADSQ_OFS_MODE, mw(4'h3, 2'h0, 1'b0, 1'b1));
    wait_for(cN, d0 + 1, "scan single irq");
    chk(chLog.size() - k, 4, "scan single count");
    k = chLog.size();
    m = mw(4'h1, 2'h0, 1'b1, 1'b1);
    apb(1'b1, `ADSQ_OFS_MODE, m);
    wait_for(cN, d0 + 3, "scan repeat irq");
    for (int i = 0; i < 4; i++) chk(chLog[k + i], i % 2, "scan order");
    apb(1'b0, `ADSQ_OFS_MODE, 0);
    chk(rd[7:6], 2'b11, "pass done busy held");
    stop_rpt(m);
    $display("test scan done");
  endtask
  task automatic t_fixrep;
    int d0, e0, n;
    logic [5:0] s0;
    logic [31:0] m;
    coreLat <= 8'h1e;
    for (int c = 0; c < 3; c++) begin
      n = (c == 0) ? 1 : (c == 1) ? 4 : 8;
      d0 = cN;
      e0 = cD;
      s0 = seq;
      m = mw(4'h5, c[1:0], 1'b1, 1'b0);
      apb(1'b1, `ADSQ_OFS_MODE, m);
      wait_for(cN, d0 + 1, "interval irq");
      chk(cD - e0, n, "conversions per irq");
      apb(1'b0, ra(3'(n - 1)), 0);
      chk(rd[9:0], {4'h5, 6'(s0 + n - 1)}, "fill slot");
      e0 = cD;
      stop_rpt(m);
      chk(cD - e0, 1, "current conversion ends");
    end
    $display("test fixed repeat done");
  endtask
  task automatic t_preempt;
    int p0, a0, e0, k;
    logic [5:0] s0;
    logic [31:0] m;
    p0 = cP;
    a0 = cA;
    e0 = cD;
    m = mw(4'h7, 2'h0, 1'b1, 1'b1);
    apb(1'b1, `ADSQ_OFS_PRIO, 32'h0000000c);
    apb(1'b1, `ADSQ_OFS_MODE, m);
    wait_for(cD, e0 + 2, "scan progress");
    s0 = seq;
    apb(1'b1, `ADSQ_OFS_PRIO, 32'h0000001c);
    k = chLog.size();
    apb(1'b1, `ADSQ_OFS_PRIO, 32'h0000001c);
    wait_for(cP, p0 + 1, "prio irq");
    apb(1'b0, `ADSQ_OFS_PRIO, 0);
    chk(rd[6:5], 2'b01, "prio done busy");
    apb(1'b0, `ADSQ_OFS_PRES, 0);
    chk(rd[9:0], {4'hc, s0}, "prio result");
    apb(1'b0, `ADSQ_OFS_MODE, 0);
    chk(rd[7], 1'b1, "normal busy kept");
    chk(chLog[k - 1], 4'h2, "suspended chan");
    chk(chLog[k], 4'hc, "prio chan");
    chk(chLog[k + 1], 4'h2, "resume chan");
    chk(cA - a0, 1, "one abort");
    stop_rpt(m);
    chk(cP - p0, 1, "retrigger ignored");
    coreLat <= 8'h08;
    $display("test preempt done");
  endtask
  task automatic t_hwtrig;
    int p0;
    logic [5:0] s0;
    for (int s = 1; s < 3; s++) begin
      p0 = cP;
      s0 = seq;
      apb(1'b1, `ADSQ_OFS_TRIG, {24'h0, s[1:0], 6'h0});
      apb(1'b1, `ADSQ_OFS_PRIO, 32'h00000006);
      @(posedge mclk);
      if (s == 1) trigPin_n <= 1'b0;
      else trigTimer <= 1'b1;
      repeat (4) @(posedge mclk);
      trigPin_n <= 1'b1;
      trigTimer <= 1'b0;
      wait_for(cP, p0 + 1, "hw trigger");
      apb(1'b0, `ADSQ_OFS_PRIO, 0);
      chk(rd[6:5], 2'b01, "prio done busy");
      apb(1'b0, `ADSQ_OFS_PRIO, 0);
      chk(rd[5], 1'b0, "prio done read clear");
      apb(1'b0, `ADSQ_OFS_PRES, 0);
      chk(rd[9:0], {4'h6, s0}, "prio result");
    end
    apb(1'b1, `ADSQ_OFS_TRIG, 0);
    $display("test hw trigger done");
  endtask
  task automatic t_monitor;
    int m0, d0;
    logic [31:0] w;
    for (int i = 0; i < 3; i++) begin
      m0 = cM;
      d0 = cN;
      w = {6'h0, (i == 2) ? 10'h3ff : 10'h010, 8'h0, 4'h2, 4'h0};
      apb(1'b1, `ADSQ_OFS_MON, w | {30'h0, i == 0, 1'b1});
      apb(1'b1, `ADSQ_OFS_MODE, mw((i == 1) ? 4'ha : 4'h2, 2'h0, 0, 0));
      wait_for(cN, d0 + 1, "monitor conv");
      chk(cM - m0, i != 1, "monitor irq");
    end
    apb(1'b0, ra(3'h2), 0);
    chk(rd[15:14], 2'b11, "monitored flags set");
    apb(1'b1, `ADSQ_OFS_MON, 0);
    $display("test monitor done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_single;
    t_scan;
    t_fixrep;
    t_preempt;
    t_hwtrig;
    t_monitor;
    complete_run;
  end
  // watchdog well beyond the expected run
  initial begin
    #400us;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire
